// File: rtl/ffo_dev.sv
`timescale 1ns/10ps
module ffo_dev #(
  parameter int DEPTH_IDX = ffo_pkg::DEPTH_MAX
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  ffo_if.dev link,
  output logic [ffo_pkg::OFS_W-1:0] o_empty_offset,
  output logic [ffo_pkg::OFS_W-1:0] o_full_offset,
  output logic o_serial_mode,
  output logic o_mem_wr,
  output logic o_mem_rd
);
  localparam logic [4:0] DIDX = 5'(DEPTH_IDX);

  // Merge one bus word into an offset register
  function automatic logic [ffo_pkg::OFS_W-1:0] ffo_merge(
    input logic [ffo_pkg::OFS_W-1:0] old,
    input logic [ffo_pkg::DATA_W-1:0] d,
    input logic [4:0] off,
    input logic [4:0] lane,
    input logic [4:0] ow
  );
    logic [ffo_pkg::OFS_W-1:0] r;
    r = old;
    for (int i = 0; i < ffo_pkg::OFS_W; i++) begin
      if ((i >= int'(off)) && (i < int'(off) + int'(lane)) && (i < int'(ow))) begin
        r[i] = d[i-int'(off)]; // [R1] [R8]
      end
    end
    return r;
  endfunction : ffo_merge

  // Extract one bus word, unused lanes read zero
  function automatic logic [ffo_pkg::DATA_W-1:0] ffo_extract(
    input logic [ffo_pkg::OFS_W-1:0] src,
    input logic [4:0] off,
    input logic [4:0] lane,
    input logic [4:0] ow
  );
    logic [ffo_pkg::DATA_W-1:0] r;
    r = '0;
    for (int j = 0; j < ffo_pkg::DATA_W; j++) begin
      if ((j < int'(lane)) && (int'(off) + j < int'(ow))) begin
        r[j] = src[int'(off)+j]; // [R2] [R8]
      end
    end
    return r;
  endfunction : ffo_extract

  logic serial_mode_r;
  logic serial_mode_nxt;
  logic in18_r;
  logic in18_nxt;
  logic out18_r;
  logic out18_nxt;
  logic [ffo_pkg::OFS_W-1:0] empty_r;
  logic [ffo_pkg::OFS_W-1:0] empty_nxt;
  logic [ffo_pkg::OFS_W-1:0] full_r;
  logic [ffo_pkg::OFS_W-1:0] full_nxt;
  logic [2:0] wp_r;
  logic [2:0] wp_nxt;
  logic [2:0] rp_r;
  logic [2:0] rp_nxt;
  logic [5:0] sc_r;
  logic [5:0] sc_nxt;
  logic [ffo_pkg::DATA_W-1:0] rdata_r;
  logic [ffo_pkg::DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic mem_wr_r;
  logic mem_wr_nxt;
  logic mem_rd_r;
  logic mem_rd_nxt;

  logic x9x9;
  logic [4:0] ow;
  logic [1:0] wr_words;
  logic [1:0] rd_words;
  logic [4:0] wr_lane;
  logic [4:0] rd_lane;
  logic ld_low;
  logic par_wr;
  logic par_rd;
  logic ser_sh;
  logic wr_full;
  logic rd_full;
  logic [1:0] wr_word;
  logic [1:0] rd_word;
  logic [4:0] wr_off;
  logic [4:0] rd_off;
  logic [5:0] ser_len;

  // Geometry from latched bus widths and depth variant
  always_comb begin
    x9x9 = !in18_r && !out18_r;
    ow = (x9x9 ? ffo_pkg::BASE_W_X9X9 : ffo_pkg::BASE_W_OTHER) + DIDX; // [R6] [R7]
    ser_len = {ow, 1'b0}; // [R4] [R5]
    if (in18_r) begin
      wr_words = ffo_pkg::WORDS_X18;
      wr_lane = ffo_pkg::LANE_X18;
    end else if (x9x9 && (DEPTH_IDX == ffo_pkg::DEPTH_MAX)) begin
      wr_words = ffo_pkg::WORDS_X9_WIDE; // [R11]
      wr_lane = ffo_pkg::LANE_X9_WIDE;
    end else begin
      wr_words = ffo_pkg::WORDS_X9; // [R9]
      wr_lane = ffo_pkg::LANE_X9;
    end
    if (out18_r) begin
      rd_words = ffo_pkg::WORDS_X18;
      rd_lane = ffo_pkg::LANE_X18;
    end else if (x9x9 && (DEPTH_IDX == ffo_pkg::DEPTH_MAX)) begin
      rd_words = ffo_pkg::WORDS_X9_WIDE; // [R11]
      rd_lane = ffo_pkg::LANE_X9_WIDE;
    end else begin
      rd_words = ffo_pkg::WORDS_X9; // [R9] [R10]
      rd_lane = ffo_pkg::LANE_X9;
    end
    wr_full = (wp_r >= {1'b0, wr_words});
    rd_full = (rp_r >= {1'b0, rd_words});
    wr_word = wr_full ? 2'(wp_r - {1'b0, wr_words}) : wp_r[1:0];
    rd_word = rd_full ? 2'(rp_r - {1'b0, rd_words}) : rp_r[1:0];
    wr_off = 5'(wr_word * wr_lane);
    rd_off = 5'(rd_word * rd_lane);
  end

  // Strobe decode, timing mode plays no part in it
  always_comb begin
    ld_low = !link.load_select_n;
    par_wr = ld_low && !link.write_strobe_n && link.read_strobe_n
      && link.serial_shift_enable_n && link.wclk_en && !serial_mode_r; // [R1] [R14]
    par_rd = ld_low && link.write_strobe_n && !link.read_strobe_n
      && link.serial_shift_enable_n && link.rclk_en; // [R2] [R13] [R14]
    ser_sh = ld_low && link.write_strobe_n && link.read_strobe_n
      && !link.serial_shift_enable_n && link.wclk_en && serial_mode_r; // [R3]
    mem_wr_nxt = !ld_low && !link.write_strobe_n && link.wclk_en; // [R15]
    mem_rd_nxt = !ld_low && !link.read_strobe_n && link.rclk_en; // [R15]
  end

  // Offset registers, pointers and serial counter
  always_comb begin
    serial_mode_nxt = serial_mode_r;
    in18_nxt = in18_r;
    out18_nxt = out18_r;
    empty_nxt = empty_r;
    full_nxt = full_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    sc_nxt = sc_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (!link.mrs_n) begin
      serial_mode_nxt = link.serial_mode; // [R12]
      in18_nxt = link.in_x18;
      out18_nxt = link.out_x18;
      empty_nxt = ffo_pkg::DEF_EMPTY_OFS;
      full_nxt = ffo_pkg::DEF_FULL_OFS;
      wp_nxt = '0; // [R16]
      rp_nxt = '0; // [R16]
      sc_nxt = '0;
    end else begin
      // Separate pointers, each moved by its own strobe
      if (par_wr) begin
        if (wr_full) begin
          full_nxt = ffo_merge(full_r, link.input_data_bus, wr_off, wr_lane, ow); // [R1]
        end else begin
          empty_nxt = ffo_merge(empty_r, link.input_data_bus, wr_off, wr_lane, ow); // [R1]
        end
        if (wp_r == 3'({wr_words, 1'b0} - 3'h1)) begin
          wp_nxt = '0; // [R17]
        end else begin
          wp_nxt = wp_r + 3'h1; // [R18]
        end
      end
      if (par_rd) begin
        rdata_nxt = ffo_extract(rd_full ? full_r : empty_r, rd_off, rd_lane, ow); // [R2]
        rvalid_nxt = 1'b1;
        if (rp_r == 3'({rd_words, 1'b0} - 3'h1)) begin
          rp_nxt = '0;
        end else begin
          rp_nxt = rp_r + 3'h1; // [R18]
        end
      end
      if (ser_sh) begin
        if (sc_r < {1'b0, ow}) begin
          empty_nxt[sc_r[4:0]] = link.serial_in; // [R3]
        end else begin
          full_nxt[5'(sc_r - {1'b0, ow})] = link.serial_in; // [R3]
        end
        sc_nxt = (sc_r == ser_len - 6'h1) ? '0 : sc_r + 6'h1;
      end
      // Any other strobe pattern leaves all state alone [R19]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial_mode_r <= 1'b0;
      in18_r <= 1'b0;
      out18_r <= 1'b0;
      empty_r <= ffo_pkg::DEF_EMPTY_OFS;
      full_r <= ffo_pkg::DEF_FULL_OFS;
      wp_r <= '0;
      rp_r <= '0;
      sc_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
    end else begin
      serial_mode_r <= serial_mode_nxt;
      in18_r <= in18_nxt;
      out18_r <= out18_nxt;
      empty_r <= empty_nxt;
      full_r <= full_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      sc_r <= sc_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      mem_wr_r <= mem_wr_nxt;
      mem_rd_r <= mem_rd_nxt;
    end
  end

  assign link.rdata = rdata_r;
  assign link.rdata_valid = rvalid_r;
  assign o_empty_offset = empty_r;
  assign o_full_offset = full_r;
  assign o_serial_mode = serial_mode_r;
  assign o_mem_wr = mem_wr_r;
  assign o_mem_rd = mem_rd_r;
endmodule : ffo_dev

// File: rtl/ffo_pkg.sv
// Functional notes
// (R1) Parallel write stores bus into next offset word
// (R2) Parallel read presents next offset word
// (R3) Serial shift one bit, empty LSB first
// (R4) x9-x9 serial set is 20 to 34 bits
// (R5) Other modes serial set is 18 to 32 bits
// (R6) x9-x9 offset width 10 to 17 bits
// (R7) Other modes offset one bit narrower
// (R8) Bits beyond offset width ignored, read undefined
// (R9) Largest x9-in or x9-out needs four cycles
// (R10) Largest x9-out readback takes four reads
// (R11) Largest x9-x9 takes six cycles, three words
// (R12) Programming method latched only at master reset
// (R13) Parallel readback allowed in either method
// (R14) Same decode in standard and fall-through timing
// (R15) Load high: strobes reach memory, else none
// (R16) Master reset homes both pointers, partial not
// (R17) Write pointer wraps after last offset word
// (R18) Independent pointers; no simultaneous read and write
// (R19) All strobes high with load low: nothing changes
package ffo_pkg;
  localparam int DATA_W = 18;
  localparam int OFS_W = 17;
  localparam int DEPTH_MAX = 7;
  localparam logic [4:0] BASE_W_X9X9 = 5'h0a;
  localparam logic [4:0] BASE_W_OTHER = 5'h09;
  localparam logic [4:0] LANE_X9 = 5'h09;
  localparam logic [4:0] LANE_X9_WIDE = 5'h08;
  localparam logic [4:0] LANE_X18 = 5'h12;
  localparam logic [1:0] WORDS_X18 = 2'h1;
  localparam logic [1:0] WORDS_X9 = 2'h2;
  localparam logic [1:0] WORDS_X9_WIDE = 2'h3;
  localparam logic [16:0] DEF_EMPTY_OFS = 17'h0007f;
  localparam logic [16:0] DEF_FULL_OFS = 17'h0007f;
  localparam int CLK_DIV_DEFAULT = 4;

  typedef enum logic [2:0] {
    CMD_MRST = 3'h0,
    CMD_PWR = 3'h1,
    CMD_PRD = 3'h2,
    CMD_SER = 3'h3,
    CMD_MWR = 3'h4,
    CMD_MRD = 3'h5
  } ffo_cmd_type;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_SETUP = 2'h1,
    HST_PULSE = 2'h3
  } ffo_hst_state_type;
endpackage : ffo_pkg

// File: rtl/ffo_if.sv
`timescale 1ns/10ps
interface ffo_if;
  logic load_select_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic serial_shift_enable_n;
  logic wclk_en;
  logic rclk_en;
  logic [ffo_pkg::DATA_W-1:0] input_data_bus;
  logic serial_in;
  logic mrs_n;
  logic serial_mode;
  logic in_x18;
  logic out_x18;
  logic [ffo_pkg::DATA_W-1:0] rdata;
  logic rdata_valid;

  modport dev (
    input load_select_n, write_strobe_n, read_strobe_n, serial_shift_enable_n,
    input wclk_en, rclk_en, input_data_bus, serial_in, mrs_n,
    input serial_mode, in_x18, out_x18,
    output rdata, rdata_valid
  );
  modport host (
    output load_select_n, write_strobe_n, read_strobe_n, serial_shift_enable_n,
    output wclk_en, rclk_en, input_data_bus, serial_in, mrs_n,
    output serial_mode, in_x18, out_x18,
    input rdata, rdata_valid
  );
endinterface : ffo_if

// File: rtl/ffo_div.sv
`timescale 1ns/10ps
module ffo_div #(
  parameter int DIV = ffo_pkg::CLK_DIV_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  output logic o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Free running divider, one-cycle tick
  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    tick_nxt = (cnt_r == LAST);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;
endmodule : ffo_div

// File: rtl/ffo_host.sv
`timescale 1ns/10ps
module ffo_host #(
  parameter int DIV = ffo_pkg::CLK_DIV_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  ffo_if.host link,
  input wire logic i_cmd_valid,
  input wire ffo_pkg::ffo_cmd_type i_cmd,
  input wire logic [ffo_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_sbit,
  input wire logic i_serial_mode,
  input wire logic i_in_x18,
  input wire logic i_out_x18,
  output logic o_busy,
  output logic [ffo_pkg::DATA_W-1:0] o_rdata,
  output logic o_rdata_valid
);
  ffo_pkg::ffo_hst_state_type st_r;
  ffo_pkg::ffo_hst_state_type st_nxt;
  logic tick;
  logic [3:0] lvl_r;
  logic [3:0] lvl_nxt;
  logic mrs_n_r;
  logic mrs_n_nxt;
  logic wclk_en_r;
  logic wclk_en_nxt;
  logic rclk_en_r;
  logic rclk_en_nxt;
  logic use_rclk_r;
  logic use_rclk_nxt;
  logic [ffo_pkg::DATA_W-1:0] data_r;
  logic [ffo_pkg::DATA_W-1:0] data_nxt;
  logic sbit_r;
  logic sbit_nxt;
  logic [2:0] strap_r;
  logic [2:0] strap_nxt;
  logic [ffo_pkg::DATA_W-1:0] rdata_r;
  logic [ffo_pkg::DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic busy_r;
  logic busy_nxt;

  ffo_div #(.DIV(DIV)) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // Levels {load_n, wen_n, ren_n, sen_n}, idle all high
  always_comb begin
    st_nxt = st_r;
    lvl_nxt = lvl_r;
    mrs_n_nxt = mrs_n_r;
    wclk_en_nxt = 1'b0;
    rclk_en_nxt = 1'b0;
    use_rclk_nxt = use_rclk_r;
    data_nxt = data_r;
    sbit_nxt = sbit_r;
    strap_nxt = strap_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = link.rdata_valid;
    if (link.rdata_valid) begin
      rdata_nxt = link.rdata;
    end
    unique case (st_r)
      ffo_pkg::HST_IDLE: begin
        if (i_cmd_valid) begin
          st_nxt = ffo_pkg::HST_SETUP;
          data_nxt = i_wdata;
          sbit_nxt = i_sbit;
          use_rclk_nxt = (i_cmd == ffo_pkg::CMD_PRD) || (i_cmd == ffo_pkg::CMD_MRD);
          // One command at a time, never read and write together [R18]
          unique case (i_cmd)
            ffo_pkg::CMD_MRST: begin
              mrs_n_nxt = 1'b0;
              strap_nxt = {i_serial_mode, i_in_x18, i_out_x18};
            end
            ffo_pkg::CMD_PWR: lvl_nxt = 4'h3; // [R9] [R11]
            ffo_pkg::CMD_PRD: lvl_nxt = 4'h5; // [R10] [R11]
            ffo_pkg::CMD_SER: lvl_nxt = 4'h6; // [R4] [R5]
            ffo_pkg::CMD_MWR: lvl_nxt = 4'hb;
            ffo_pkg::CMD_MRD: lvl_nxt = 4'hd;
            // Spare codes: offset access with all strobes idle
            default: begin
              lvl_nxt = 4'h7; // [R19]
              use_rclk_nxt = i_cmd[0];
            end
          endcase
        end
      end
      ffo_pkg::HST_SETUP: begin
        if (tick) begin
          st_nxt = ffo_pkg::HST_PULSE;
          wclk_en_nxt = !use_rclk_r;
          rclk_en_nxt = use_rclk_r;
        end
      end
      ffo_pkg::HST_PULSE: begin
        st_nxt = ffo_pkg::HST_IDLE;
        lvl_nxt = 4'hf;
        mrs_n_nxt = 1'b1;
      end
      default: st_nxt = ffo_pkg::HST_IDLE;
    endcase
    busy_nxt = (st_nxt != ffo_pkg::HST_IDLE);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ffo_pkg::HST_IDLE;
      lvl_r <= 4'hf;
      mrs_n_r <= 1'b1;
      wclk_en_r <= 1'b0;
      rclk_en_r <= 1'b0;
      use_rclk_r <= 1'b0;
      data_r <= '0;
      sbit_r <= 1'b0;
      strap_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      lvl_r <= lvl_nxt;
      mrs_n_r <= mrs_n_nxt;
      wclk_en_r <= wclk_en_nxt;
      rclk_en_r <= rclk_en_nxt;
      use_rclk_r <= use_rclk_nxt;
      data_r <= data_nxt;
      sbit_r <= sbit_nxt;
      strap_r <= strap_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign link.load_select_n = lvl_r[3];
  assign link.write_strobe_n = lvl_r[2];
  assign link.read_strobe_n = lvl_r[1];
  assign link.serial_shift_enable_n = lvl_r[0];
  assign link.wclk_en = wclk_en_r;
  assign link.rclk_en = rclk_en_r;
  assign link.input_data_bus = data_r;
  assign link.serial_in = sbit_r;
  assign link.mrs_n = mrs_n_r;
  assign link.serial_mode = strap_r[2];
  assign link.in_x18 = strap_r[1];
  assign link.out_x18 = strap_r[0];
  assign o_busy = busy_r;
  assign o_rdata = rdata_r;
  assign o_rdata_valid = rvalid_r;
endmodule : ffo_host

// File: test/ffo_assertions.sv
`timescale 1ns/10ps
module ffo_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic load_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic serial_shift_enable_n,
  input wire logic wclk_en,
  input wire logic rclk_en,
  input wire logic mrs_n,
  input wire logic out_x18,
  input wire logic [ffo_pkg::DATA_W-1:0] rdata,
  input wire logic rdata_valid
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_par_rd;
    rclk_en && !load_select_n && write_strobe_n && !read_strobe_n
      && serial_shift_enable_n && mrs_n;
  endsequence
  sequence s_idle_rd;
    rclk_en && !load_select_n && write_strobe_n && read_strobe_n && serial_shift_enable_n;
  endsequence

  property p_rd_answer;
    s_par_rd |=> rdata_valid;
  endproperty
  property p_valid_cause;
    rdata_valid |-> $past(rclk_en) && !$past(read_strobe_n) && !$past(load_select_n);
  endproperty
  property p_noop;
    s_idle_rd |=> !rdata_valid;
  endproperty
  property p_mem_rd;
    rclk_en && load_select_n |=> !rdata_valid;
  endproperty
  property p_one_op;
    !(wclk_en && rclk_en);
  endproperty
  property p_hold;
    !rdata_valid && mrs_n && $past(mrs_n) |-> $stable(rdata);
  endproperty
  property p_lane;
    rdata_valid && !out_x18 |-> rdata[17:9] == 9'h000;
  endproperty
  property p_mrs;
    !mrs_n |=> !rdata_valid;
  endproperty
  property p_pulse;
    wclk_en |=> !wclk_en;
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("readback missing");
  a_valid_cause: assert property (p_valid_cause) else $error("stray readback");
  a_noop: assert property (p_noop) else $error("readback on no-op");
  a_mem_rd: assert property (p_mem_rd) else $error("readback on memory read");
  a_one_op: assert property (p_one_op) else $error("read and write together");
  a_hold: assert property (p_hold) else $error("readback changed unasked");
  a_lane: assert property (p_lane) else $error("unused bits set");
  a_mrs: assert property (p_mrs) else $error("readback in master reset");
  a_pulse: assert property (p_pulse) else $error("write edge too long");
endmodule : ffo_assertions

// File: test/ffo_bench.sv
`timescale 1ns/10ps
module ffo_bench;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  ffo_pkg::ffo_cmd_type cmd = ffo_pkg::CMD_MRST;
  logic [17:0] wdata = 18'h00000;
  logic sbit = 1'b0;
  logic ser = 1'b0;
  logic in18 = 1'b0;
  logic out18 = 1'b0;
  logic busy;
  logic rvalid;
  logic [17:0] rdata;
  logic [16:0] e_ofs;
  logic [16:0] f_ofs;
  logic ser_q;
  logic mem_wr;
  logic mem_rd;
  logic [3:0] w_lvl = 4'h0;
  logic [3:0] r_lvl = 4'h0;
  logic [31:0] seed = 32'heb8e;
  int miscompares = 0;
  int n_compared = 0;
  int wr_seen = 0;
  int rd_seen = 0;
  int rv_seen = 0;
  int n_rd = 0;
  logic [31:0] exp_e = 32'h0;
  logic [31:0] exp_f = 32'h0;

  ffo_if link();
  ffo_host #(.DIV(2)) ffo_host_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(link),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wdata(wdata), .i_sbit(sbit),
    .i_serial_mode(ser), .i_in_x18(in18), .i_out_x18(out18), .o_busy(busy),
    .o_rdata(rdata), .o_rdata_valid(rvalid));
  ffo_dev #(.DEPTH_IDX(7)) ffo_dev_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .link(link),
    .o_empty_offset(e_ofs), .o_full_offset(f_ofs), .o_serial_mode(ser_q),
    .o_mem_wr(mem_wr), .o_mem_rd(mem_rd));
  ffo_assertions ffo_assertions_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .load_select_n(link.load_select_n), .write_strobe_n(link.write_strobe_n),
    .read_strobe_n(link.read_strobe_n), .serial_shift_enable_n(link.serial_shift_enable_n),
    .wclk_en(link.wclk_en), .rclk_en(link.rclk_en), .mrs_n(link.mrs_n),
    .out_x18(link.out_x18), .rdata(link.rdata), .rdata_valid(link.rdata_valid));

  always #2.5 i_clk_sys = ~i_clk_sys;

  // Wire levels seen at each port edge, memory pulses counted
  always @(posedge i_clk_sys) begin
    if (link.wclk_en === 1'b1) w_lvl = {link.load_select_n, link.write_strobe_n,
      link.read_strobe_n, link.serial_shift_enable_n};
    if (link.rclk_en === 1'b1) r_lvl = {link.load_select_n, link.write_strobe_n,
      link.read_strobe_n, link.serial_shift_enable_n};
    if (mem_wr === 1'b1) wr_seen++;
    if (mem_rd === 1'b1) rd_seen++;
    if (rvalid === 1'b1) rv_seen++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic issue(input ffo_pkg::ffo_cmd_type c, input logic [17:0] d, input logic b);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    cmd_valid <= 1'b1;
    cmd <= c;
    wdata <= d;
    sbit <= b;
    @(posedge i_clk_sys);
    cmd_valid <= 1'b0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h1, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask : issue

  // One strap set: master reset, program both offsets, read them back
  task automatic run(input logic s, input logic a, input logic b);
    logic [31:0] acc [2];
    logic [31:0] r;
    logic [31:0] om;
    int ow, li, lo, ni, no, sel;
    ow = (!a && !b) ? 17 : 16;
    li = a ? 18 : ((!a && !b) ? 8 : 9);
    lo = b ? 18 : ((!a && !b) ? 8 : 9);
    ni = (ow + li - 1) / li;
    no = (ow + lo - 1) / lo;
    om = (32'h1 << ow) - 1;
    @(posedge i_clk_sys);
    ser <= s;
    in18 <= a;
    out18 <= b;
    issue(ffo_pkg::CMD_MRST, 18'h00000, 1'b0);
    chk(e_ofs, 32'h7f);
    chk(f_ofs, 32'h7f);
    chk(ser_q, s);
    for (int rep = 0; rep < 2; rep++) begin
      acc[0] = 0;
      acc[1] = 0;
      for (int k = 0; k < (s ? 2 * ow : 2 * ni); k++) begin
        r = rnd();
        sel = s ? k / ow : k / ni;
        if (s) begin
          issue(ffo_pkg::CMD_SER, 18'h00000, r[0]);
          acc[sel] |= {31'h0, r[0]} << (k % ow);
        end else begin
          issue(ffo_pkg::CMD_PWR, r[17:0], 1'b0);
          acc[sel] |= (r & ((32'h1 << li) - 1)) << ((k % ni) * li);
        end
      end
      chk(w_lvl, s ? 4'h6 : 4'h3);
      chk(e_ofs, acc[0] & om);
      chk(f_ofs, acc[1] & om);
    end
    if (s) begin
      issue(ffo_pkg::CMD_PWR, 18'(rnd()), 1'b0);
      chk(e_ofs, acc[0] & om);
    end
    for (int k = 0; k < 2 * no; k++) begin
      issue(ffo_pkg::CMD_PRD, 18'h00000, 1'b0);
      n_rd++;
      r = ((acc[k / no] & om) >> ((k % no) * lo)) & ((32'h1 << lo) - 1);
      chk(rdata, r);
    end
    chk(r_lvl, 4'h5);
    exp_e = acc[0] & om;
    exp_f = acc[1] & om;
  endtask : run

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    run(1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b0, 1'b1);
    run(1'b0, 1'b0, 1'b0);
    run(1'b0, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b0);
    run(1'b1, 1'b1, 1'b1);
    // Offset access with all strobes high, on each port edge
    issue(ffo_pkg::ffo_cmd_type'(3'h6), 18'h3ffff, 1'b1);
    issue(ffo_pkg::ffo_cmd_type'(3'h7), 18'h00000, 1'b0);
    chk(w_lvl, 4'h7);
    chk(r_lvl, 4'h7);
    chk(e_ofs, exp_e);
    chk(f_ofs, exp_f);
    chk(rdata, exp_f);
    issue(ffo_pkg::CMD_PRD, 18'h00000, 1'b0);
    n_rd++;
    chk(rdata, exp_e);
    chk(rv_seen, n_rd);
    issue(ffo_pkg::CMD_MWR, 18'(rnd()), 1'b0);
    chk(wr_seen, 1);
    issue(ffo_pkg::CMD_MRD, 18'h00000, 1'b0);
    chk(rd_seen, 1);
    chk(w_lvl[3], 1'b1);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    close_out();
  end
endmodule : ffo_bench
